// [dspl_defs.svh]
// constants of the dac serial port and load control block
`ifndef DSPL_DEFS_SVH
`define DSPL_DEFS_SVH

// ----------------------------------------------------------------
// frame and data widths
// ----------------------------------------------------------------
`define DSPL_FRAME_BITS 24
`define DSPL_FRAME_LEN 5'h18
`define DSPL_CNT_BITS 5
`define DSPL_WORD_BITS 12
`define DSPL_CHANNELS 8
`define DSPL_CH_BITS 3
`define DSPL_SYNC_W 5

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DSPL_CLK_NS 50
`define DSPL_T9_NS 5
`define DSPL_T9_RAW ((`DSPL_T9_NS + `DSPL_CLK_NS - 1) / `DSPL_CLK_NS)
`define DSPL_T9_CYC ((`DSPL_T9_RAW < 1) ? 1 : `DSPL_T9_RAW)
`define DSPL_GUARD_BITS 3
`define DSPL_MODE_SETTLE 2'h3

`endif

// [dspl_pkg.sv]
// types of the dac serial port and load control block
package dspl_pkg;

  // serial interface states, one-hot
  typedef enum logic [2:0]
  {
    DSPL_IDLE = 3'h1,
    DSPL_SHIFT = 3'h2,
    DSPL_SLEEP = 3'h4
  } dspl_state_e;

endpackage : dspl_pkg

// [dspl_sync.sv]
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns

module dspl_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input logic clk_sys,
  input logic rst_n,
  input logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= INIT;
      q <= INIT;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : dspl_sync

// [dspl_port.sv]
// serial port, sleep bypass and dac latch load control
//
// Contract
// [RULE_01] disable bit clear: output drives during frames
// [RULE_02] disable bit set: output always high-impedance
// [RULE_03] strobe low: latches follow data registers
// [RULE_04] asynchronous mode: strobe tied low before power
// [RULE_05] synchronous mode: strobe high through power-on
// [RULE_06] wake-up low returns interface from sleep
// [RULE_07] strobe low, engine off: reload after write
// [RULE_08] daisy-chain: latch on strobe fall, after guard; code also loads on a fall inside the guard and flags load_timing_err
// [RULE_09] input sampled on serial clock falling edge
// [RULE_10] output bit launched after serial clock rise
// [RULE_11] output drives on select fall, releases on rise
// [RULE_12] sleeping daisy-chain: input bypassed to output
// [RULE_13] serial clock and input ignored while deselected
// [RULE_14] update mode caught after reset, held
// [RULE_15] disable bit clear after reset
`timescale 1ns/1ns
`include "dspl_defs.svh"

module dspl_port (
  input logic clk_sys,
  input logic resetn,
  input logic sclk,
  input logic cs_n,
  input logic sdi,
  output logic sdo,
  output logic sdo_oe_n,
  input logic latch_load_strobe_n,
  input logic wakeup_n,
  input logic serial_out_disable_bit,
  input logic daisy_chain_en,
  input logic corr_engine_en,
  input logic sleep_req,
  input logic [`DSPL_FRAME_BITS-1:0] tx_word,
  output logic [`DSPL_FRAME_BITS-1:0] rx_word,
  output logic rx_valid,
  input logic data_wr,
  input logic [`DSPL_CH_BITS-1:0] data_wr_ch,
  input logic [`DSPL_WORD_BITS-1:0] data_wr_val,
  output logic [`DSPL_CHANNELS*`DSPL_WORD_BITS-1:0] dac_latch,
  output logic async_mode,
  output logic sleeping,
  output logic load_timing_err
);

  // ----------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_pipe;
  logic rst_n;
  logic [`DSPL_SYNC_W-1:0] pins_s;
  logic sclk_s, cs_n_s, sdi_s, latch_load_strobe_n_s, wake_s;

  // release is clocked; assertion stays asynchronous
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      rst_pipe <= 2'h0;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_n = rst_pipe[1];

  // idle levels: select, strobe and wake-up all inactive high
  dspl_sync #(.WIDTH(`DSPL_SYNC_W), .INIT(5'h1B)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d({sclk, cs_n, sdi, latch_load_strobe_n, wakeup_n}),
    .q(pins_s)
  );
  assign {sclk_s, cs_n_s, sdi_s, latch_load_strobe_n_s, wake_s} = pins_s;

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  logic sclk_q, cs_n_q, latch_load_strobe_n_q;
  logic sclk_fall, sclk_rise, cs_fall, cs_rise, latch_load_strobe_n_fall;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_q <= 1'b1;
      cs_n_q <= 1'b1;
      latch_load_strobe_n_q <= 1'b1;
    end
    else
    begin
      sclk_q <= sclk_s;
      cs_n_q <= cs_n_s;
      latch_load_strobe_n_q <= latch_load_strobe_n_s;
    end
  end
  assign sclk_fall = sclk_q & ~sclk_s;
  assign sclk_rise = ~sclk_q & sclk_s;
  assign cs_fall = cs_n_q & ~cs_n_s;
  assign cs_rise = ~cs_n_q & cs_n_s;
  assign latch_load_strobe_n_fall = latch_load_strobe_n_q & ~latch_load_strobe_n_s;

  // ----------------------------------------------------------------
  // interface state
  // ----------------------------------------------------------------
  dspl_pkg::dspl_state_e state, next_state;
  logic active, bypass;

  // sleep only makes sense in a chain; entered between frames
  always_comb
  begin
    next_state = state;
    case (state)
      dspl_pkg::DSPL_IDLE:
        if (sleep_req && daisy_chain_en)
          next_state = dspl_pkg::DSPL_SLEEP;
        else if (cs_fall)
          next_state = dspl_pkg::DSPL_SHIFT;
      dspl_pkg::DSPL_SHIFT:
        if (cs_rise)
          next_state = dspl_pkg::DSPL_IDLE;
      dspl_pkg::DSPL_SLEEP:
        if (!wake_s)
          next_state = dspl_pkg::DSPL_IDLE; // [RULE_06]
      default:
        next_state = dspl_pkg::DSPL_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      state <= dspl_pkg::DSPL_IDLE;
    else
      state <= next_state;
  end
  assign active = (state == dspl_pkg::DSPL_SHIFT);
  assign sleeping = (state == dspl_pkg::DSPL_SLEEP);
  assign bypass = sleeping & daisy_chain_en;

  // ----------------------------------------------------------------
  // shift registers
  // ----------------------------------------------------------------
  logic [`DSPL_FRAME_BITS-1:0] rx_shift, tx_shift;
  logic [`DSPL_CNT_BITS-1:0] bit_cnt;
  logic frame_done;

  // frames under 24 bits are dropped silently; longer frames keep the last 24
  assign frame_done = active & cs_rise & (bit_cnt == `DSPL_FRAME_LEN);

  // only selected frames move data; idle clocks are ignored
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_shift <= '0;
      tx_shift <= '0;
      bit_cnt <= '0;
    end
    else if (state == dspl_pkg::DSPL_IDLE && cs_fall)
    begin
      tx_shift <= tx_word;
      bit_cnt <= '0;
    end
    else if (active && sclk_fall) // [RULE_13]
    begin
      rx_shift <= {rx_shift[`DSPL_FRAME_BITS-2:0], sdi_s}; // [RULE_09]
      if (bit_cnt != `DSPL_FRAME_LEN)
        bit_cnt <= bit_cnt + 1'b1;
    end
    else if (active && sclk_rise && bit_cnt != '0)
      tx_shift <= {tx_shift[`DSPL_FRAME_BITS-2:0], 1'b0}; // [RULE_10]
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_word <= '0;
      rx_valid <= 1'b0;
    end
    else
    begin
      rx_valid <= frame_done;
      if (frame_done)
        rx_word <= rx_shift;
    end
  end

  // ----------------------------------------------------------------
  // serial output and its enable
  // ----------------------------------------------------------------
  // bypass is a pure wire path so chain latency stays at gate delay
  assign sdo = bypass ? sdi : tx_shift[`DSPL_FRAME_BITS-1]; // [RULE_12]
  // disable bit wins over all; owner clears it at reset [RULE_15]
  assign sdo_oe_n = serial_out_disable_bit | ~(active | bypass); // [RULE_01] [RULE_02] [RULE_11]

  // ----------------------------------------------------------------
  // update mode capture
  // ----------------------------------------------------------------
  logic [1:0] settle;
  logic mode_done;

  // waits for the synchroniser to hold real pin levels
  assign mode_done = (settle == `DSPL_MODE_SETTLE);
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      settle <= 2'h0;
      async_mode <= 1'b0;
    end
    else if (!mode_done)
    begin
      settle <= settle + 1'b1;
      async_mode <= ~latch_load_strobe_n_s; // [RULE_14] [RULE_04] [RULE_05]
    end
  end

  // ----------------------------------------------------------------
  // data registers and dac latches
  // ----------------------------------------------------------------
  logic [`DSPL_CHANNELS-1:0][`DSPL_WORD_BITS-1:0] data_reg, latch_q;
  logic [`DSPL_WORD_BITS-1:0] stage_val;
  logic [`DSPL_CH_BITS-1:0] stage_ch;
  logic stage_busy, load_now, level_load;
  logic [`DSPL_GUARD_BITS-1:0] guard;

  // correction costs one cycle; without it the write lands at once
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_reg <= '0;
      stage_val <= '0;
      stage_ch <= '0;
      stage_busy <= 1'b0;
    end
    else
    begin
      stage_busy <= data_wr & corr_engine_en;
      if (data_wr && corr_engine_en)
      begin
        stage_val <= data_wr_val;
        stage_ch <= data_wr_ch;
      end
      if (data_wr && !corr_engine_en)
        data_reg[data_wr_ch] <= data_wr_val; // [RULE_07]
      else if (stage_busy)
        data_reg[stage_ch] <= stage_val;
    end
  end

  // level load outside chains; edge load inside; tied low always loads
  assign level_load = ~latch_load_strobe_n_s & mode_done; // [RULE_03]
  assign load_now = mode_done & (async_mode |
    (daisy_chain_en ? latch_load_strobe_n_fall : level_load)); // [RULE_08]

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      latch_q <= '0;
    else if (load_now)
      latch_q <= data_reg; // [RULE_03] [RULE_07]
  end
  assign dac_latch = latch_q;

  // in a chain, strobe too soon after select rise gives a flagged, unsafe load
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      guard <= '0;
      load_timing_err <= 1'b0;
    end
    else
    begin
      if (cs_rise)
        guard <= '0;
      else if (guard != `DSPL_GUARD_BITS'(`DSPL_T9_CYC))
        guard <= guard + 1'b1;
      load_timing_err <= daisy_chain_en & latch_load_strobe_n_fall & (cs_rise |
        (guard < `DSPL_GUARD_BITS'(`DSPL_T9_CYC))); // [RULE_08]
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_dis_hiz; // [RULE_02]
    @(posedge clk_sys) disable iff (!rst_n)
    serial_out_disable_bit |-> sdo_oe_n;
  endproperty
  a_dis_hiz: assert property (p_dis_hiz) else $error("sdo driven while disabled");

  property p_drive; // [RULE_01]
    @(posedge clk_sys) disable iff (!rst_n)
    (cs_fall && state == dspl_pkg::DSPL_IDLE && !sleep_req
      && !serial_out_disable_bit) ##1 !serial_out_disable_bit |-> !sdo_oe_n;
  endproperty
  a_drive: assert property (p_drive) else $error("sdo not driven in frame");

  property p_release; // [RULE_11]
    @(posedge clk_sys) disable iff (!rst_n)
    (active && cs_rise) |=> sdo_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("sdo held after deselect");

  property p_level_load; // [RULE_03]
    @(posedge clk_sys) disable iff (!rst_n)
    (mode_done && !daisy_chain_en && !latch_load_strobe_n_s) |=> dac_latch == $past(data_reg);
  endproperty
  a_level_load: assert property (p_level_load) else $error("latch not transparent");

  property p_reload; // [RULE_07]
    @(posedge clk_sys) disable iff (!rst_n)
    (data_wr && !corr_engine_en && mode_done && !daisy_chain_en && !latch_load_strobe_n_s)
      ##1 !latch_load_strobe_n_s |=> latch_q[$past(data_wr_ch, 2)] == $past(data_wr_val, 2);
  endproperty
  a_reload: assert property (p_reload) else $error("latch not reloaded after write");

  property p_edge_only; // [RULE_08]
    @(posedge clk_sys) disable iff (!rst_n)
    (daisy_chain_en && !async_mode && !latch_load_strobe_n_fall) |=> $stable(dac_latch);
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("chain latch moved off edge");

  property p_sample; // [RULE_09]
    @(posedge clk_sys) disable iff (!rst_n)
    (active && sclk_fall) |=> rx_shift[0] == $past(sdi_s);
  endproperty
  a_sample: assert property (p_sample) else $error("input bit not sampled");

  property p_ignore; // [RULE_13]
    @(posedge clk_sys) disable iff (!rst_n)
    !active |=> $stable(rx_shift) && !rx_valid;
  endproperty
  a_ignore: assert property (p_ignore) else $error("input taken while deselected");

  property p_launch; // [RULE_10]
    @(posedge clk_sys) disable iff (!rst_n)
    (active && sclk_rise && !sclk_fall && bit_cnt != '0) |=>
      tx_shift == {$past(tx_shift[`DSPL_FRAME_BITS-2:0]), 1'b0};
  endproperty
  a_launch: assert property (p_launch) else $error("output bit not launched");

  property p_bypass; // [RULE_12]
    @(posedge clk_sys) disable iff (!rst_n)
    bypass |-> (sdo == sdi) && (sdo_oe_n == serial_out_disable_bit);
  endproperty
  a_bypass: assert property (p_bypass) else $error("sleep bypass broken");

  property p_wake; // [RULE_06]
    @(posedge clk_sys) disable iff (!rst_n)
    (sleeping && !wake_s) |=> state == dspl_pkg::DSPL_IDLE;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake from sleep");

  property p_mode_hold; // [RULE_14]
    @(posedge clk_sys) disable iff (!rst_n)
    mode_done |=> $stable(async_mode) && mode_done;
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("update mode changed");

endmodule : dspl_port

// [dspl_host_model.sv]
// host serial controller model driving the serial pins
`timescale 1ns/1ns

module dspl_host_model (
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input logic sdo,
  input logic sdo_oe_n
);
  logic last;

  // ----------------------------------------------------------------
  // idle pins
  // ----------------------------------------------------------------
  // clock stands high between frames
  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b1;
    sdi = 1'b0;
    last = 1'b0;
  end

  // ----------------------------------------------------------------
  // frame of n bits, msb first, 400 ns serial clock
  // ----------------------------------------------------------------
  // an undriven line reads as the inverse of the last bit
  task automatic frame(input int n, input logic [23:0] tx,
    output logic [23:0] rx, output int drv);
    cs_n = 1'b0;
    drv = 0;
    rx = 24'h000000;
    #400;
    for (int i = n - 1; i >= 0; i--)
    begin
      sdi = tx[i];
      #200 sclk = 1'b0;
      last = (sdo_oe_n === 1'b0) ? sdo : ~last;
      rx = {rx[22:0], last};
      drv = drv + ((sdo_oe_n === 1'b0) ? 1 : 0);
      #200 sclk = 1'b1;
    end
    #200 cs_n = 1'b1;
    sdi = ~sdi;
    #400;
  endtask : frame

  // clock and data wiggle while deselected
  task automatic noise(input int n);
    for (int i = 0; i < n; i++)
    begin
      sdi = ~sdi;
      #200 sclk = ~sclk;
    end
  endtask : noise

  // raw data level, used while the port sleeps
  task automatic poke(input logic b);
    sdi = b;
  endtask : poke
endmodule : dspl_host_model

// [testbench.sv]
// self-checking bench of the dac serial port and load control
`timescale 1ns/1ns
`include "dspl_defs.svh"

module testbench;
  logic clk_sys, resetn, strobe_n, wake_n, dis, dce, cee, slp;
  logic data_wr, sclk, cs_n, sdi, sdo, sdo_oe_n, rx_valid;
  logic async_mode, sleeping, lerr;
  logic [23:0] tx_word, rx_word, got, t;
  logic [2:0] ch;
  logic [11:0] val, v;
  logic [95:0] dac_latch;
  logic [11:0] mdl [8];
  int failures = 0, checks = 0, nv = 0, nerr = 0, cyc = 0, drv;
  integer seed;

  dspl_port dut (.clk_sys(clk_sys), .resetn(resetn), .sclk(sclk),
    .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
    .latch_load_strobe_n(strobe_n), .wakeup_n(wake_n),
    .serial_out_disable_bit(dis), .daisy_chain_en(dce),
    .corr_engine_en(cee), .sleep_req(slp), .tx_word(tx_word),
    .rx_word(rx_word), .rx_valid(rx_valid), .data_wr(data_wr),
    .data_wr_ch(ch), .data_wr_val(val), .dac_latch(dac_latch),
    .async_mode(async_mode), .sleeping(sleeping),
    .load_timing_err(lerr));

  dspl_host_model host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe_n(sdo_oe_n));

  // ----------------------------------------------------------------
  // clock, pulse counters, hang guard
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // a run needs about 2400 cycles; 20000 means a hang
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (rx_valid === 1'b1) nv <= nv + 1;
    if (lerr === 1'b1) nerr <= nerr + 1;
    if (cyc == 20000)
    begin
      failures++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // expected latch image from the channel model
  function automatic logic [95:0] pack();
    logic [95:0] p;
    for (int i = 0; i < 8; i++) p[i*12 +: 12] = mdl[i];
    return p;
  endfunction : pack

  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : step

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  // strobe must stay put well past mode capture
  task automatic rst(input logic s);
    strobe_n = s;
    resetn = 1'b0;
    step(16);
    resetn = 1'b1;
    step(12);
    for (int i = 0; i < 8; i++) mdl[i] = 12'h000;
  endtask : rst

  task automatic wr(input logic [2:0] c, input logic [11:0] x);
    data_wr = 1'b1;
    ch = c;
    val = x;
    step(1);
    data_wr = 1'b0;
    step(5);
  endtask : wr

  // off-phase start keeps pin edges away from the clock edges
  task automatic xfer(input int n, input logic [23:0] s,
    input logic [23:0] tw);
    tx_word = tw;
    @(negedge clk_sys);
    #7 host.frame(n, s, got, drv);
  endtask : xfer

  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 24;
    {data_wr, ch, val, tx_word} = '0;
    {wake_n, dis, dce, cee, slp} = 5'h10;
    rst(1'b1);
    chk(async_mode, 1'b0);
    chk(sdo_oe_n, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      t = (i == 0) ? 24'hFFFFFF : (i == 1) ? 24'h000001 : 24'($random(seed));
      xfer(24, t, {t[11:0], t[23:12]});
      chk(got, {t[11:0], t[23:12]});
      chk(drv, 24);
      chk(rx_word, t);
      chk(sdo_oe_n, 1'b1);
    end
    host.noise(30);
    xfer(23, ~t, t);
    step(8);
    chk(nv, 6);
    chk(rx_word, t);
    dis = 1'b1;
    xfer(24, t, t);
    chk(drv, 0);
    dis = 1'b0;
    done("serial");
    strobe_n = 1'b0;
    step(4);
    for (int i = 0; i < 9; i++)
    begin
      cee = (i == 8);
      v = 12'($random(seed));
      wr(i[2:0], v);
      mdl[i[2:0]] = v;
      chk(dac_latch, pack());
    end
    cee = 1'b0;
    strobe_n = 1'b1;
    step(4);
    wr(3'h5, 12'hABC);
    chk(dac_latch, pack());
    strobe_n = 1'b0;
    step(5);
    mdl[5] = 12'hABC;
    chk(dac_latch, pack());
    done("level");
    dce = 1'b1;
    step(4);
    wr(3'h2, 12'h123);
    chk(dac_latch, pack());
    strobe_n = 1'b1;
    xfer(24, t, t);
    step(2);
    strobe_n = 1'b0;
    step(5);
    mdl[2] = 12'h123;
    chk(dac_latch, pack());
    chk(nerr, 0);
    strobe_n = 1'b1;
    wr(3'h3, 12'h456);
    // strobe falls 2 ns after select rises, inside the guard
    fork
      xfer(24, t, t);
      begin
        @(posedge cs_n);
        #2 strobe_n = 1'b0;
      end
    join
    step(3);
    mdl[3] = 12'h456;
    chk(dac_latch, pack());
    chk(nerr, 1);
    slp = 1'b1;
    step(1);
    slp = 1'b0;
    step(3);
    chk(sleeping, 1'b1);
    for (int b = 0; b < 2; b++)
    begin
      host.poke(b[0]);
      #20 chk(sdo, b[0]);
      step(1);
    end
    wake_n = 1'b0;
    step(6);
    chk(sleeping, 1'b0);
    wake_n = 1'b1;
    dce = 1'b0;
    done("chain");
    rst(1'b0);
    chk(async_mode, 1'b1);
    strobe_n = 1'b1;
    step(4);
    wr(3'h7, 12'hFED);
    mdl[7] = 12'hFED;
    chk(dac_latch, pack());
    done("async");
    summarize();
  end
endmodule : testbench
